// ==== rtl/sgds_pin_cell.sv ====
// One pad cell: input synchroniser, port/peripheral output select and power-down hold.
// Assumes the pad itself resolves the wire from pinOut and pinOe; all inputs but pinIn are on clk.
`timescale 1ns/10ps
module sgds_pin_cell (
	input wire logic clk,
	input wire logic nrst,
	input wire logic freeze,
	input wire logic altSel,
	input wire logic dirOut,
	input wire logic dataOut,
	input wire logic altOut,
	input wire logic altOe,
	input wire logic pinIn,
	output logic pinOut,
	output logic pinOe,
	output logic pinSync
);
	logic metaQ;
	logic syncQ;
	logic outQ;
	logic oeQ;
	logic outD;
	logic oeD;

	// Port control only acts while the pin is in general-purpose mode.
	assign outD = altSel ? altOut : dataOut;
	assign oeD = altSel ? altOe : dirOut;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			metaQ <= 1'b0;
			syncQ <= 1'b0;
		end else begin
			metaQ <= pinIn;
			syncQ <= metaQ;
		end
	end

	// While frozen the pad keeps its last level so the board sees no glitch.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			outQ <= 1'b0;
			oeQ <= 1'b0;
		end else if (!freeze) begin
			outQ <= outD;
			oeQ <= oeD;
		end
	end

	assign pinOut = outQ;
	assign pinOe = oeQ;
	assign pinSync = syncQ;

endmodule : sgds_pin_cell

// ==== rtl/sgds_pkg.sv ====
// Constants, field layout and carrier types for the six-pin port block.
// Assumes a 32-bit APB master on the same clock and register addresses decoded in full.
package sgds_pkg;

	localparam int PIN_COUNT = 6;

	localparam logic [31:0] ADDR_FUNC_SEL = 32'hFFFF0D00;
	localparam logic [31:0] ADDR_DATA = 32'hFFFF0D10;
	localparam logic [31:0] ADDR_SET = 32'hFFFF0D14;
	localparam logic [31:0] ADDR_POWER = 32'hFFFF0D1C;

	localparam int DIR_LSB = 24;
	localparam int OUT_LSB = 16;
	localparam int IN_LSB = 0;
	localparam int FSEL_STRIDE = 4;
	localparam int PWR_DOWN_BIT = 0;

	localparam logic [31:0] DATA_RESET = 32'h000000FF;
	localparam logic [PIN_COUNT-1:0] FSEL_RESET = 6'h00;
	localparam logic PWR_RESET = 1'b0;

	typedef struct packed {
		logic [PIN_COUNT-1:0] dir;
		logic [PIN_COUNT-1:0] dout;
	} sgds_port_t;

	typedef struct packed {
		logic [PIN_COUNT-1:0] sel;
		logic [PIN_COUNT-1:0] out;
		logic [PIN_COUNT-1:0] oe;
	} sgds_alt_t;

endpackage : sgds_pkg

// ==== rtl/sgds_top.sv ====
// Six-pin general-purpose port with data/direction register and set-only register on APB.
// Assumes an APB master on clk, pins that need synchronising, and peripheral lines on clk.
//
// Design decision made here: the APB register port.
`timescale 1ns/10ps
module sgds_top
	import sgds_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic [31:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [PIN_COUNT-1:0] altOut,
	input wire logic [PIN_COUNT-1:0] altOe,
	output logic [PIN_COUNT-1:0] altIn,
	input wire logic [PIN_COUNT-1:0] pinIn,
	output logic [PIN_COUNT-1:0] pinOut,
	output logic [PIN_COUNT-1:0] pinOe
);
	sgds_port_t portQ;
	sgds_port_t portD;
	logic [PIN_COUNT-1:0] fselQ;
	logic [PIN_COUNT-1:0] fselD;
	logic pwrDownQ;
	logic pwrDownD;
	logic readyQ;
	logic slverrQ;
	logic [31:0] rdataQ;
	logic [31:0] rdataD;
	logic [PIN_COUNT-1:0] pinSync;
	sgds_alt_t alt;

	// Bus phase and address decode.
	wire setupPhase = psel & ~penable;
	wire accessDone = psel & penable & readyQ;
	wire hitFsel = (paddr == ADDR_FUNC_SEL);
	wire hitData = (paddr == ADDR_DATA);
	wire hitSet = (paddr == ADDR_SET);
	wire hitPower = (paddr == ADDR_POWER);
	wire hitAny = hitFsel | hitData | hitSet | hitPower;
	wire wrFsel = accessDone & pwrite & hitFsel;
	wire wrData = accessDone & pwrite & hitData;
	wire wrSet = accessDone & pwrite & hitSet;
	wire wrPower = accessDone & pwrite & hitPower;

	wire [PIN_COUNT-1:0] wrDir = pwdata[DIR_LSB +: PIN_COUNT];
	wire [PIN_COUNT-1:0] wrOut = pwdata[OUT_LSB +: PIN_COUNT];
	wire [PIN_COUNT-1:0] setMask = pwdata[OUT_LSB +: PIN_COUNT];

	// Input-data bits are never stored, so a write to them has nothing to land in.
	// The set register only ORs ones into the output latch; a zero never clears.
	assign portD.dir = wrData ? wrDir : portQ.dir;
	assign portD.dout = wrData ? wrOut :
		(wrSet ? (portQ.dout | setMask) : portQ.dout);

	logic [PIN_COUNT-1:0] fselWr;
	logic [31:0] fselRead;
	always_comb begin
		fselWr = '0;
		fselRead = '0;
		for (int i = 0; i < PIN_COUNT; i++) begin
			fselWr[i] = pwdata[i*FSEL_STRIDE];
			fselRead[i*FSEL_STRIDE] = fselQ[i];
		end
	end
	assign fselD = wrFsel ? fselWr : fselQ;
	assign pwrDownD = wrPower ? pwdata[PWR_DOWN_BIT] : pwrDownQ;

	// Read data is captured in the setup cycle so the pins seen are those of that edge.
	wire [31:0] dataRead = {2'h0, portQ.dir, 2'h0, portQ.dout, 10'h000, pinSync};
	wire [31:0] powerRead = {31'h00000000, pwrDownQ};
	assign rdataD = hitFsel ? fselRead :
		hitData ? dataRead :
		hitPower ? powerRead : 32'h00000000;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			portQ.dir <= DATA_RESET[DIR_LSB +: PIN_COUNT];
			portQ.dout <= DATA_RESET[OUT_LSB +: PIN_COUNT];
			fselQ <= FSEL_RESET;
			pwrDownQ <= PWR_RESET;
		end else begin
			portQ <= portD;
			fselQ <= fselD;
			pwrDownQ <= pwrDownD;
		end
	end

	// Every transfer completes in its first access cycle; unmapped addresses error.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			readyQ <= 1'b0;
			slverrQ <= 1'b0;
			rdataQ <= 32'h00000000;
		end else begin
			readyQ <= setupPhase;
			slverrQ <= setupPhase & ~hitAny;
			if (setupPhase & ~pwrite) begin
				rdataQ <= rdataD;
			end
		end
	end

	assign prdata = rdataQ;
	assign pready = readyQ;
	assign pslverr = slverrQ;

	assign alt.sel = fselQ;
	assign alt.out = altOut;
	assign alt.oe = altOe;

	genvar g;
	generate
		for (g = 0; g < PIN_COUNT; g++) begin : gPin
			sgds_pin_cell uCell (
				.clk(clk),
				.nrst(nrst),
				.freeze(pwrDownQ),
				.altSel(alt.sel[g]),
				.dirOut(portQ.dir[g]),
				.dataOut(portQ.dout[g]),
				.altOut(alt.out[g]),
				.altOe(alt.oe[g]),
				.pinIn(pinIn[g]),
				.pinOut(pinOut[g]),
				.pinOe(pinOe[g]),
				.pinSync(pinSync[g])
			);
		end
	endgenerate

	// The peripherals see the same synchronised levels that software reads.
	assign altIn = pinSync;

	// A gpio pin with direction 0 is released one edge later.
	a_input_released: assert property (
		@(posedge clk) disable iff (!nrst)
		$past(!pwrDownQ) |-> ((pinOe & ~$past(fselQ) & ~$past(portQ.dir)) == '0)
	) else $error("gpio input pin is being driven");

	// A gpio pin with direction 1 is driven one edge later.
	a_output_enabled: assert property (
		@(posedge clk) disable iff (!nrst)
		$past(!pwrDownQ) |-> ((~pinOe & ~$past(fselQ) & $past(portQ.dir)) == '0)
	) else $error("gpio output pin is not driven");

	// The pin level follows the stored output bit.
	a_output_level: assert property (
		@(posedge clk) disable iff (!nrst)
		$past(!pwrDownQ) |-> (((pinOut ^ $past(portQ.dout)) & ~$past(fselQ)) == '0)
	) else $error("gpio pin level differs from output data");

	// A data read returns the pins as synchronised at the setup edge, reserved bits 15:6 zero.
	a_input_readback: assert property (
		@(posedge clk) disable iff (!nrst)
		(accessDone && !pwrite && hitData) |->
			(prdata[IN_LSB +: PIN_COUNT] == $past(pinSync)) && (prdata[15:6] == 10'h000)
	) else $error("input data read mismatch");

	// Set bits reach the output latch one edge and the pins two edges after the write.
	a_set_drives: assert property (
		@(posedge clk) disable iff (!nrst)
		(wrSet && !pwrDownQ && !pwrDownD) |-> ##2
			((pinOut & ~fselQ & $past(setMask, 2)) == ($past(setMask, 2) & ~fselQ))
	) else $error("set write did not drive pin high");

	// Zero bits leave both output and direction alone.
	a_set_zero_keeps: assert property (
		@(posedge clk) disable iff (!nrst)
		wrSet |=> (((portQ.dout ^ $past(portQ.dout)) & ~$past(setMask)) == '0)
			&& $stable(portQ.dir)
	) else $error("set write changed an unselected pin");

	// A later data read shows the bits that a set write raised.
	a_set_stored: assert property (
		@(posedge clk) disable iff (!nrst)
		wrSet |=> (portQ.dout == ($past(portQ.dout) | $past(setMask)))
	) else $error("set write not kept in output data");

	// Selected pins follow the peripheral, not the port registers.
	a_alt_follows: assert property (
		@(posedge clk) disable iff (!nrst)
		$past(!pwrDownQ) |->
			(((pinOut ^ $past(altOut)) | (pinOe ^ $past(altOe))) & $past(fselQ)) == '0
	) else $error("peripheral pin not following its function");

	// Held pins do not move while power-down stays on.
	a_powerdown_hold: assert property (
		@(posedge clk) disable iff (!nrst)
		$past(pwrDownQ) |-> $stable(pinOut) && $stable(pinOe)
	) else $error("pin changed during power-down");

	// A transfer is answered in its first access cycle.
	a_bus_answer: assert property (
		@(posedge clk) disable iff (!nrst)
		setupPhase |=> pready && (pslverr == !$past(hitAny))
	) else $error("bus transfer not answered in one cycle");

endmodule : sgds_top

// ==== verif/sgds_board.sv ====
// Board model of the six pads: internal pull-ups plus an optional external driver.
// Assumes the port drives a pad only while its enable is high.
`timescale 1ns/10ps
module sgds_board
	import sgds_pkg::*;
(
	input wire logic [PIN_COUNT-1:0] pinOut,
	input wire logic [PIN_COUNT-1:0] pinOe,
	input wire logic [PIN_COUNT-1:0] extVal,
	input wire logic [PIN_COUNT-1:0] extEn,
	output logic [PIN_COUNT-1:0] pinIn
);
	// A released pad with no external driver floats high through its pull-up, never to a stale level.
	always_comb begin
		for (int i = 0; i < PIN_COUNT; i++) begin
			pinIn[i] = pinOe[i] ? pinOut[i] : (extEn[i] ? extVal[i] : 1'b1);
		end
	end
endmodule : sgds_board

// ==== verif/testbench.sv ====
// Self-checking bench for the six-pin port: APB master tasks and pad model.
// Assumes zero-wait APB answers are not relied on; every wait is bounded.
`timescale 1ns/10ps
module testbench
	import sgds_pkg::*;
;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [31:0] paddr = 32'h0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [PIN_COUNT-1:0] altOut = 6'h00;
	logic [PIN_COUNT-1:0] altOe = 6'h00;
	logic [PIN_COUNT-1:0] altIn;
	logic [PIN_COUNT-1:0] pinIn;
	logic [PIN_COUNT-1:0] pinOut;
	logic [PIN_COUNT-1:0] pinOe;
	logic [PIN_COUNT-1:0] extVal = 6'h00;
	logic [PIN_COUNT-1:0] extEn = 6'h00;
	logic [31:0] rdv;
	logic erv;
	int failures = 0;
	int n_checks = 0;
	always #2.5 clk = ~clk;
	sgds_top i_sgds_top (.clk(clk), .nrst(nrst), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .altOut(altOut), .altOe(altOe),
		.altIn(altIn), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe));
	sgds_board i_sgds_board (.pinOut(pinOut), .pinOe(pinOe), .extVal(extVal),
		.extEn(extEn), .pinIn(pinIn));
	task automatic apb(input logic [31:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1'b1;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1 && n < 20) begin
			n++;
			@(posedge clk);
		end
		if (n >= 20) failures++;
		rdv = prdata;
		erv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		n_checks++;
		if (got !== ex) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
		end
	endtask : chk
	task automatic stop_test();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : stop_test
	task automatic t_reset();
		// The pad synchronisers need two edges after reset before they show the pull-ups.
		repeat (3) @(posedge clk);
		apb(ADDR_DATA, 1'b0, 32'h0);
		chk("data after reset", 32'h0000003F, rdv);
		chk("enable after reset", 32'h0, 32'(pinOe));
		$display("reset test done");
	endtask : t_reset
	task automatic t_output();
		apb(ADDR_DATA, 1'b1, 32'h3F2A0000);
		repeat (3) @(posedge clk);
		chk("pin enables", 32'h3F, 32'(pinOe));
		chk("pin levels", 32'h2A, 32'(pinOut));
		apb(ADDR_DATA, 1'b0, 32'h0);
		chk("data readback", 32'h3F2A002A, rdv);
		$display("output test done");
	endtask : t_output
	task automatic t_set();
		apb(ADDR_SET, 1'b1, 32'h00050000);
		repeat (3) @(posedge clk);
		chk("pins after set", 32'h2F, 32'(pinOut));
		apb(ADDR_DATA, 1'b0, 32'h0);
		chk("data after set", 32'h3F2F002F, rdv);
		apb(ADDR_SET, 1'b0, 32'h0);
		chk("set reads zero", 32'h0, rdv);
		chk("set read no error", 32'h0, 32'(erv));
		$display("set test done");
	endtask : t_set
	task automatic t_input();
		apb(ADDR_DATA, 1'b1, 32'h0000003F);
		extVal <= 6'h15;
		extEn <= 6'h3F;
		repeat (6) @(posedge clk);
		chk("input enables", 32'h0, 32'(pinOe));
		apb(ADDR_DATA, 1'b0, 32'h0);
		chk("input bits", 32'h00000015, rdv);
		chk("peripheral input", 32'h15, 32'(altIn));
		extEn <= 6'h00;
		$display("input test done");
	endtask : t_input
	task automatic t_alt();
		apb(ADDR_DATA, 1'b1, 32'h01000000);
		apb(ADDR_FUNC_SEL, 1'b1, 32'h00000001);
		altOut <= 6'h01;
		altOe <= 6'h01;
		repeat (3) @(posedge clk);
		chk("peripheral owns pin", 32'h3, {30'h0, pinOe[0], pinOut[0]});
		apb(ADDR_FUNC_SEL, 1'b1, 32'h0);
		repeat (3) @(posedge clk);
		chk("port owns pin", 32'h2, {30'h0, pinOe[0], pinOut[0]});
		$display("function select test done");
	endtask : t_alt
	task automatic t_power();
		apb(ADDR_DATA, 1'b1, 32'h3F150000);
		apb(ADDR_POWER, 1'b1, 32'h00000001);
		apb(ADDR_DATA, 1'b1, 32'h3F2A0000);
		repeat (3) @(posedge clk);
		chk("pins held", 32'h15, 32'(pinOut));
		apb(ADDR_POWER, 1'b1, 32'h0);
		repeat (3) @(posedge clk);
		chk("pins after wake", 32'h2A, 32'(pinOut));
		apb(32'hFFFF0D18, 1'b0, 32'h0);
		chk("unmapped error", 32'h1, 32'(erv));
		$display("power and unmapped test done");
	endtask : t_power
	initial begin
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		t_reset();
		t_output();
		t_set();
		t_input();
		t_alt();
		t_power();
		stop_test();
	end
	// The full sequence needs well under a thousand cycles.
	initial begin
		#20000;
		failures++;
		stop_test();
	end
endmodule : testbench
